/* File: common/plb_pkg.sv */
// constants and carrier types for the port latch and bus strobe block
package plb_pkg;

  // register map: port latches, pin views, own control words
  localparam logic [7:0] PORT_BASE = 8'h80;
  localparam logic [3:0] PORT_STRIDE_SH = 4'h4;
  localparam logic [7:0] PIN_VIEW_OFS = 8'h08;
  localparam logic [7:0] CTRL_ADDR = 8'hf8;
  localparam logic [7:0] ANALOG_ADDR = 8'hf9;
  localparam logic [7:0] STATUS_ADDR = 8'hfa;

  // reset values
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] ANALOG_RST = 8'h00;
  localparam logic [1:0] P4_MASK = 2'h3;

  // oscillator periods per machine cycle, normal and double speed
  localparam logic [3:0] MC_STD = 4'hc;
  localparam logic [3:0] MC_DBL = 4'h6;
  // address phase length inside each half machine cycle
  localparam logic [3:0] ADR_PH_STD = 4'h3;
  localparam logic [3:0] ADR_PH_DBL = 4'h1;
  // machine cycles the reset pin must stay high
  localparam logic [4:0] RST_MCYCLES = 5'h02;
  // first program address that lives outside internal flash
  localparam logic [15:0] CODE_LIMIT = 16'h8000;

  localparam int SYNC_W = 42;

  typedef struct packed {
    logic [5:0] rsvd;
    logic double_speed_mode;
    logic ale_off;
  } plb_ctrl_t;

  localparam plb_ctrl_t CTRL_RST = '{rsvd: 6'h00, double_speed_mode: 1'b0, ale_off: 1'b0};

  // pin drive bundle: o is the level driven while oe is high,
  // pu is the weak internal pull-up
  typedef struct packed {
    logic [4:0][7:0] o;
    logic [4:0][7:0] oe;
    logic [4:0][7:0] pu;
  } plb_drive_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] stab;
    logic [4:0][7:0] latch;
    plb_ctrl_t ctrl;
    logic [7:0] analog;
    logic [3:0] ph;
    logic [4:0] rst_cnt;
    logic dev_rst;
    logic [7:0] rdata;
    logic ale;
    logic program_fetch_strobe_n;
    logic fetch_ext;
    plb_drive_t drv;
  } plb_state_t;

endpackage : plb_pkg

/* File: core/plb_port_block.sv */
// port latches, pin drivers and external memory strobes
//
// What this block does
// RQ1 - reset pin high two machine cycles resets
// RQ2 - address latch pulse every six or three periods
// RQ3 - software may stop address latch on internal fetch
// RQ4 - fetch strobe twice per machine cycle externally
// RQ5 - two fetch strobes skipped per data access
// RQ6 - fetch strobe idle for internal fetches
// RQ7 - select high: internal below 8000h
// RQ8 - select low: every fetch is external
// RQ9 - port write loads the latch
// RQ10 - latch read returns stored latch bits
// RQ11 - pin read returns synchronised pin levels
// RQ12 - each line independently input or output
// RQ13 - zero drives low, one releases pin
// RQ14 - ports 1,3,4 follow alternate output
// RQ15 - ports 0,2 carry address/data in bus cycles
// RQ16 - bus cycles override general purpose use
// RQ17 - port 0 drives ones only in bus cycles
// RQ18 - port 2 drives ones in bus cycles
// RQ19 - port 1 pull-up off for analog pins
// RQ20 - any reset sets all latches to one
// RQ21 - pin levels synchronised before use
`timescale 1ns/1ps
`default_nettype none

module plb_port_block (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic RESET_PIN,
  input wire logic EXT_FETCH_SEL,
  input wire logic [15:0] PC,
  input wire logic CODE_FETCH,
  input wire logic XDATA_ACCESS,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [7:0] BUS_DOUT,
  input wire logic BUS_WRITE,
  input wire logic [7:0] ALT1_OUT,
  input wire logic [7:0] ALT3_OUT,
  input wire logic [1:0] ALT4_OUT,
  input wire logic [4:0][7:0] PIN_IN,
  output plb_pkg::plb_drive_t PIN_DRV,
  output logic ALE,
  output logic PROG_FETCH_STROBE_N,
  output logic FETCH_EXTERNAL,
  output logic DEV_RESET
);

  localparam plb_pkg::plb_state_t STATE_RST = '{
    latch: {5{plb_pkg::LATCH_RST}},
    ctrl: plb_pkg::CTRL_RST,
    analog: plb_pkg::ANALOG_RST,
    program_fetch_strobe_n: 1'b1,
    default: '0
  };

  plb_pkg::plb_state_t q;
  plb_pkg::plb_state_t n;

  logic [4:0][7:0] pins_s;
  logic ea_s;
  logic rpin_s;
  logic [3:0] mc_len;
  logic [3:0] half;
  logic [3:0] hph;
  logic [3:0] adr_ph;
  logic [4:0] rst_lim;
  logic fetch_ext_c;
  logic ext_fetch_on;
  logic bus_cycle;
  logic ale_tick;
  logic ale_dis;
  logic [4:0][7:0] alt;
  logic [7:0] port_addr;
  logic lv;

  // stable views of the synchronised pins
  assign pins_s = q.stab[39:0];
  assign ea_s = q.stab[40];
  assign rpin_s = q.stab[41];

  always_comb begin
    n = q;
    port_addr = 8'h00;
    lv = 1'b0;

    // RQ21 three stage sync
    // a bit only moves once stages two and three agree,
    // which also filters single-cycle glitches
    n.s1 = {RESET_PIN, EXT_FETCH_SEL, PIN_IN};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.stab = (q.s2 & q.s3) | (q.stab & (q.s2 | q.s3));

    // machine cycle phase counter
    mc_len = q.ctrl.double_speed_mode ? plb_pkg::MC_DBL : plb_pkg::MC_STD;
    half = mc_len >> 1;
    adr_ph = q.ctrl.double_speed_mode ? plb_pkg::ADR_PH_DBL : plb_pkg::ADR_PH_STD;
    hph = (q.ph < half) ? q.ph : 4'(q.ph - half);
    // wraps on >= so a speed change mid-cycle never runs past the end
    n.ph = (q.ph >= 4'(mc_len - 4'h1)) ? 4'h0 : 4'(q.ph + 4'h1);

    // RQ1 reset pin qualifier
    // counts clocks of a high pin, saturating at the limit
    rst_lim = 5'(plb_pkg::RST_MCYCLES * {1'b0, mc_len});
    if (!rpin_s) begin
      n.rst_cnt = 5'h00;
    end else if (q.rst_cnt != rst_lim) begin
      n.rst_cnt = 5'(q.rst_cnt + 5'h01);
    end
    n.dev_rst = rpin_s && (q.rst_cnt == rst_lim);

    // RQ7 code map split
    // RQ8 all external when select low
    fetch_ext_c = !ea_s || (PC >= plb_pkg::CODE_LIMIT);
    n.fetch_ext = fetch_ext_c;
    ext_fetch_on = CODE_FETCH && fetch_ext_c;
    bus_cycle = ext_fetch_on || XDATA_ACCESS;

    // RQ2 address latch timing
    ale_tick = (q.ph == 4'h0) || (q.ph == half);
    // RQ3 software address latch off
    ale_dis = q.ctrl.ale_off && ea_s && !fetch_ext_c;
    n.ale = ale_tick && !XDATA_ACCESS && !ale_dis;

    // RQ4 two fetch strobes per cycle
    // RQ5 skipped during data access
    // RQ6 idle on internal fetch
    n.program_fetch_strobe_n = !(ext_fetch_on && !XDATA_ACCESS && (hph >= adr_ph));

    // RQ9 latch write
    // a write in the same cycle as a detected reset loses
    if (WR) begin
      for (int i = 0; i < 5; i++) begin
        port_addr = 8'(plb_pkg::PORT_BASE + (8'(i) << plb_pkg::PORT_STRIDE_SH));
        if (ADDR == port_addr) begin
          n.latch[i] = WDATA;
        end
      end
      if (ADDR == plb_pkg::CTRL_ADDR) begin
        n.ctrl = plb_pkg::plb_ctrl_t'({6'h00, WDATA[1:0]});
      end
      if (ADDR == plb_pkg::ANALOG_ADDR) begin
        n.analog = WDATA;
      end
    end
    n.latch[4][7:2] = 6'h3f;

    // RQ20 latches to one on reset
    if (q.dev_rst) begin
      n.latch = {5{plb_pkg::LATCH_RST}};
      n.ctrl = plb_pkg::CTRL_RST;
      n.analog = plb_pkg::ANALOG_RST;
    end

    // read data stands for one cycle only, zero otherwise
    n.rdata = 8'h00;
    if (RD) begin
      for (int i = 0; i < 5; i++) begin
        port_addr = 8'(plb_pkg::PORT_BASE + (8'(i) << plb_pkg::PORT_STRIDE_SH));
        // RQ10 latch read path
        if (ADDR == port_addr) begin
          n.rdata = (i == 4) ? {6'h00, q.latch[4][1:0]} : q.latch[i];
        end
        // RQ11 pin read path
        if (ADDR == 8'(port_addr + plb_pkg::PIN_VIEW_OFS)) begin
          n.rdata = (i == 4) ? {6'h00, pins_s[4][1:0]} : pins_s[i];
        end
      end
      if (ADDR == plb_pkg::CTRL_ADDR) begin
        n.rdata = q.ctrl;
      end
      if (ADDR == plb_pkg::ANALOG_ADDR) begin
        n.rdata = q.analog;
      end
      if (ADDR == plb_pkg::STATUS_ADDR) begin
        n.rdata = {4'h0, q.fetch_ext, bus_cycle, ea_s, q.dev_rst};
      end
    end

    // alternate outputs; ports 0 and 2 have none
    alt[0] = 8'hff;
    alt[1] = ALT1_OUT;
    alt[2] = 8'hff;
    alt[3] = ALT3_OUT;
    alt[4] = {6'h3f, ALT4_OUT};

    // RQ12 per-line drive
    // each bit is worked out alone from its own latch bit
    for (int i = 0; i < 5; i++) begin
      for (int b = 0; b < 8; b++) begin
        // RQ14 alternate function gating
        lv = q.latch[i][b] && alt[i][b];
        // RQ13 zero pulls low
        n.drv.o[i][b] = 1'b0;
        n.drv.oe[i][b] = !lv;
        n.drv.pu[i][b] = (i != 0);
      end
    end

    // RQ19 analog pins lose pull-up
    n.drv.pu[1] = ~q.analog;

    // port 4 has two lines; the rest stay released
    n.drv.oe[4][7:2] = 6'h00;
    n.drv.pu[4][7:2] = 6'h00;

    // RQ15 bus takes the drivers
    // RQ16 latches ignored meanwhile
    if (bus_cycle) begin
      // RQ18 port 2 full drive
      n.drv.o[2] = BUS_ADDR[15:8];
      n.drv.oe[2] = 8'hff;
      // RQ17 port 0 strong only here
      // address first, then write data or released for reads
      if (hph < adr_ph) begin
        n.drv.o[0] = BUS_ADDR[7:0];
        n.drv.oe[0] = 8'hff;
      end else if (BUS_WRITE && XDATA_ACCESS) begin
        n.drv.o[0] = BUS_DOUT;
        n.drv.oe[0] = 8'hff;
      end else begin
        n.drv.o[0] = 8'h00;
        n.drv.oe[0] = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      q <= STATE_RST;
    end else begin
      q <= n;
    end
  end

  assign RDATA = q.rdata;
  assign PIN_DRV = q.drv;
  assign ALE = q.ale;
  assign PROG_FETCH_STROBE_N = q.program_fetch_strobe_n;
  assign FETCH_EXTERNAL = q.fetch_ext;
  assign DEV_RESET = q.dev_rst;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // reset only after the full qualification count
  reset_qual_a: assert property ( // RQ1
    $rose(q.dev_rst) |-> $past(q.rst_cnt) == $past(rst_lim) && $past(rpin_s))
    else $error("reset raised before qualification");

  // pulses land on the half machine cycle ticks
  ale_tick_a: assert property ( // RQ2
    q.ale |-> ($past(q.ph) == 4'h0) || ($past(q.ph) == $past(half)))
    else $error("address latch off its tick");

  ale_xdata_a: assert property ( // RQ2
    $past(XDATA_ACCESS) |-> !q.ale)
    else $error("address latch during data access");

  ale_off_a: assert property ( // RQ3
    $past(q.ctrl.ale_off && ea_s && !fetch_ext_c) |-> !q.ale)
    else $error("address latch not disabled");

  program_fetch_strobe_pulse_a: assert property ( // RQ4
    (q.ph == 4'h3 && ext_fetch_on && !XDATA_ACCESS && !q.ctrl.double_speed_mode)
    |=> !q.program_fetch_strobe_n)
    else $error("fetch strobe missing");

  program_fetch_strobe_skip_a: assert property ( // RQ5
    XDATA_ACCESS |=> q.program_fetch_strobe_n)
    else $error("fetch strobe during data access");

  program_fetch_strobe_int_a: assert property ( // RQ6
    (CODE_FETCH && !fetch_ext_c) |=> q.program_fetch_strobe_n)
    else $error("fetch strobe on internal fetch");

  fetch_low_a: assert property ( // RQ7
    (ea_s && PC < plb_pkg::CODE_LIMIT) |=> !q.fetch_ext)
    else $error("low address fetched externally");

  fetch_all_a: assert property ( // RQ8
    !ea_s |=> q.fetch_ext)
    else $error("internal fetch with select low");

  latch_wr_a: assert property ( // RQ9
    (WR && ADDR == 8'h90 && !q.dev_rst) |=> q.latch[1] == $past(WDATA))
    else $error("port write lost");

  latch_rd_a: assert property ( // RQ10
    (RD && ADDR == 8'hb0) |=> RDATA == $past(q.latch[3]))
    else $error("latch read wrong");

  zero_drive_a: assert property ( // RQ13
    (q.latch[3][0] == 1'b0) |=> q.drv.oe[3][0] && !q.drv.o[3][0])
    else $error("zero latch not driving low");

  p0_open_a: assert property ( // RQ17
    !bus_cycle |=> !(q.drv.oe[0][0] && q.drv.o[0][0]))
    else $error("port 0 drove high outside bus");

  latch_rst_a: assert property ( // RQ20
    q.dev_rst |=> q.latch[2] == plb_pkg::LATCH_RST)
    else $error("latch not set by reset");

  // RQ21 agreeing stages pass
  pin_sync_a: assert property ( // RQ21
    (q.s2 == q.s3) |=> q.stab == $past(q.s2))
    else $error("synchroniser did not follow agreed level");

  // RQ11 pin read value
  pin_read_a: assert property ( // RQ11
    (RD && ADDR == 8'h98) |=> RDATA == $past(pins_s[1]))
    else $error("pin read wrong");

  // RQ19 analog pull-up off
  analog_pu_a: assert property ( // RQ19
    1'b1 |=> q.drv.pu[1] == ~$past(q.analog))
    else $error("port 1 pull-up not following analog select");

  // RQ14 alternate output follows
  alt_out_a: assert property ( // RQ14
    q.latch[1][0] |=> q.drv.oe[1][0] == !$past(ALT1_OUT[0]))
    else $error("alternate output not followed");

  // RQ12 line set alone
  line_indep_a: assert property ( // RQ12
    (q.latch[3][1] && ALT3_OUT[1]) |=> !q.drv.oe[3][1])
    else $error("released line driven");

  // RQ15 port 2 carries address
  bus_addr_a: assert property ( // RQ15
    bus_cycle |=> q.drv.o[2] == $past(BUS_ADDR[15:8]))
    else $error("port 2 not carrying address");

  // RQ16 latches overridden
  bus_own_a: assert property ( // RQ16
    bus_cycle |=> q.drv.oe[2] == 8'hff)
    else $error("port 2 left to latches in bus cycle");

  // RQ18 port 2 drives ones
  p2_drive_a: assert property ( // RQ18
    (bus_cycle && BUS_ADDR[8]) |=> q.drv.oe[2][0] && q.drv.o[2][0])
    else $error("port 2 did not drive one");

endmodule : plb_port_block

`default_nettype wire

/* File: bench/plb_mem_model.sv */
// far side model: pin wires, address latch, strobe counters
`timescale 1ns/1ps
`default_nettype none
module plb_mem_model (
  input wire logic clk,
  input wire plb_pkg::plb_drive_t drv,
  input wire logic [4:0][7:0] ext_v,
  input wire logic [4:0][7:0] ext_oe,
  input wire logic ale,
  input wire logic strobe_n,
  output logic [4:0][7:0] pin,
  output logic [7:0] addr_lo,
  output int ale_cnt,
  output int fetch_cnt
);
  logic [4:0][7:0] last = '0;
  logic strobe_q = 1'b1;
  initial begin
    ale_cnt = 0;
    fetch_cnt = 0;
    addr_lo = '0;
  end
  // floating lines show the inverse level, never a stale one
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      for (int b = 0; b < 8; b++) begin
        pin[p][b] = drv.oe[p][b] ? drv.o[p][b] : ext_oe[p][b] ? ext_v[p][b] :
          drv.pu[p][b] ? 1'b1 : ~last[p][b];
      end
    end
  end
  always @(posedge clk) begin
    last <= pin;
    strobe_q <= strobe_n;
    if (ale) begin
      addr_lo <= pin[0];
    end
    ale_cnt <= ale_cnt + int'(ale);
    fetch_cnt <= fetch_cnt + int'(strobe_q & ~strobe_n);
  end
endmodule : plb_mem_model
`default_nettype wire

/* File: bench/tb_port_latch_and_bus_strobes.sv */
// self-checking bench: registers, pins, strobes, pin reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_port_latch_and_bus_strobes;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, rpin = 0, sel = 0, cf = 0, xd = 0, bw = 0;
  logic [7:0] addr = '0, wdata = '0, a1 = 8'hff, d, alo, rdata, bd = 8'h3c;
  logic [15:0] pc = '0, ba = 16'h1234;
  logic [4:0][7:0] ev = '0, eo = '0, pin;
  logic [31:0] lf = 32'h1938;
  logic ale, psn, fx, drst;
  plb_pkg::plb_drive_t drv;
  int errors = 0, checked = 0, ac, fc, na, nf;
  int lat [4];
  plb_port_block i_plb_port_block (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .RESET_PIN(rpin), .EXT_FETCH_SEL(sel), .PC(pc),
    .CODE_FETCH(cf), .XDATA_ACCESS(xd), .BUS_ADDR(ba), .BUS_DOUT(bd), .BUS_WRITE(bw),
    .ALT1_OUT(a1), .ALT3_OUT(8'hff), .ALT4_OUT(2'h3), .PIN_IN(pin), .PIN_DRV(drv),
    .ALE(ale), .PROG_FETCH_STROBE_N(psn), .FETCH_EXTERNAL(fx), .DEV_RESET(drst));
  plb_mem_model i_plb_mem_model (.clk(clk), .drv(drv), .ext_v(ev), .ext_oe(eo), .ale(ale),
    .strobe_n(psn), .pin(pin), .addr_lo(alo), .ale_cnt(ac), .fetch_cnt(fc));
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction : rnd
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  // any 12 clocks hold two half machine cycles at normal speed, four at double speed
  task automatic win(input int settle);
    int a0;
    int f0;
    repeat (settle) @(posedge clk);
    a0 = ac;
    f0 = fc;
    repeat (12) @(posedge clk);
    na = ac - a0;
    nf = fc - f0;
  endtask : win
  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 5; p++) begin
      rd_reg(8'h80 + 8'(p * 16), d);
      `CHK("latch reset", (p < 4 ? 8'hff : 8'h03), d)
    end
    for (int p = 0; p < 4; p++) begin
      lat[p] = int'(rnd());
      wr_reg(8'h80 + 8'(p * 16), 8'(lat[p]));
    end
    a1 <= rnd();
    repeat (3) @(posedge clk);
    for (int p = 0; p < 4; p++) begin
      rd_reg(8'h80 + 8'(p * 16), d);
      `CHK("latch read", 8'(lat[p]), d)
      `CHK("drive oe", ~(8'(lat[p]) & (p == 1 ? a1 : 8'hff)), drv.oe[p])
      `CHK("drive o", 8'h00, drv.o[p])
    end
    wr_reg(8'h90, 8'hff);
    a1 <= 8'hff;
    ev[1] <= rnd();
    eo[1] <= 8'hff;
    repeat (6) @(posedge clk);
    rd_reg(8'h98, d);
    `CHK("pin read", ev[1], d)
    wr_reg(8'hf9, 8'h5a);
    rd_reg(8'h85, d);
    `CHK("unmapped", 8'h00, d)
    `CHK("pull-up", 8'ha5, drv.pu[1])
    cf <= 1'b1;
    win(8);
    `CHK("ale ext", 2, na)
    `CHK("fetch ext", 2, nf)
    `CHK("port2 oe", 8'hff, drv.oe[2])
    `CHK("port2 o", ba[15:8], drv.o[2])
    `CHK("addr low", ba[7:0], alo)
    xd <= 1'b1;
    bw <= 1'b1;
    bd <= rnd();
    win(4);
    `CHK("ale xdata", 0, na)
    `CHK("fetch xdata", 0, nf)
    for (int i = 0; i < 12 && !(drv.oe[0] === 8'hff && drv.o[0] === bd); i++) @(posedge clk);
    `CHK("port0 data", bd, drv.o[0])
    `CHK("port0 data oe", 8'hff, drv.oe[0])
    xd <= 1'b0;
    bw <= 1'b0;
    wr_reg(8'hf8, 8'h02);
    win(4);
    `CHK("ale double", 4, na)
    `CHK("fetch double", 4, nf)
    wr_reg(8'hf8, 8'h01);
    sel <= 1'b1;
    pc <= 16'h7fff;
    win(8);
    `CHK("ale off", 0, na)
    `CHK("fetch int", 0, nf)
    `CHK("fetch ext flag", 1'b0, fx)
    pc <= 16'h8000;
    win(4);
    `CHK("fetch ext flag", 1'b1, fx)
    `CHK("fetch high", 2, nf)
    `CHK("ale high", 2, na)
    // pin held well past two machine cycles
    rpin <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK("reset early", 1'b0, drst)
    for (int i = 0; i < 20 && drst !== 1'b1; i++) @(posedge clk);
    `CHK("reset seen", 1'b1, drst)
    wr_reg(8'h90, 8'h00);
    rd_reg(8'h90, d);
    `CHK("latch forced", 8'hff, d)
    rd_reg(8'hf8, d);
    `CHK("ctrl cleared", 8'h00, d)
    rpin <= 1'b0;
    conclude();
  end
endmodule : tb_port_latch_and_bus_strobes
`default_nettype wire
